// [hw/porc_pkg.sv]
package porc_pkg;

  // ***********************************
  // clock and power-on delays
  // ***********************************
  localparam int CLK_MHZ = 250;
  localparam int POR_DELAY_LOW_US = 3000;
  localparam int POR_DELAY_MID_US = 7000;
  localparam int POR_DELAY_HIGH_US = 15000;
  localparam int POR_DELAY_LOW_CYC = POR_DELAY_LOW_US * CLK_MHZ;
  localparam int POR_DELAY_MID_CYC = POR_DELAY_MID_US * CLK_MHZ;
  localparam int POR_DELAY_HIGH_CYC = POR_DELAY_HIGH_US * CLK_MHZ;
  localparam int DELAY_W = 24;
  localparam int WDT_DIV = 12;

  // ***********************************
  // register map (byte addresses)
  // ***********************************
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_PMU_MODE = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY_MON = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // reset_cause_register fields
  localparam int CAUSE_PIN_BIT = 0;
  localparam int POWER_ON_FLAG_BIT = 1;
  localparam int CAUSE_MON_BIT = 2;
  localparam int CAUSE_SW_BIT = 3;
  localparam int CAUSE_EXT_BIT = 4;
  // power_unit_mode_register field
  localparam int BATTERY_MONITOR_DISABLE_BIT = 5;
  // supply monitor control field
  localparam int SUPPLY_MON_EN_BIT = 7;

  localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  typedef enum logic [1:0] {
    ST_POR_WAIT,
    ST_POR_DELAY,
    ST_HOLD,
    ST_RUN
  } porc_state_type;

endpackage : porc_pkg

// [hw/porc_delay_timer.sv]
`timescale 1ns/1ps

module porc_delay_timer #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // status
  output logic done
);

  logic [WIDTH-1:0] count;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0) && !load;

endmodule : porc_delay_timer

// [hw/porc_controller.sv]
`timescale 1ns/1ps

// How it works
// RULE1: any reset halts core, defaults registers, ports
// RULE2: ram kept, stack pointer reinitialised
// RULE3: port latches all ones, open drain, pullups
// RULE4: pin floats on power-on, driven on monitor
// RULE5: exit clears pc, internal oscillator selected
// RULE6: watchdog enabled, clocked system clock over twelve
// RULE7: first fetch from address zero always
// RULE8: hold until battery good, then level delay
// RULE9: power-on exit sets power-on flag
// RULE10: other flags zeroed; other resets clear flag
// RULE11: software treats ram undefined after power-on
// RULE12: disable bit five stops battery monitor
// RULE13: monitor off: any reset runs full power-on
// RULE14: power-on or power-fail re-arm supply monitor
// RULE15: supply monitor reset skips power-on delay
// RULE16: causes combined, fast assert, synchronous release
module porc_controller #(
  parameter int DELAY_LOW_CYC = porc_pkg::POR_DELAY_LOW_CYC,
  parameter int DELAY_MID_CYC = porc_pkg::POR_DELAY_MID_CYC,
  parameter int DELAY_HIGH_CYC = porc_pkg::POR_DELAY_HIGH_CYC,
  parameter bit HAS_MON_DISABLE = 1'b1
) (
  // clock and power-on reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply monitors and reset sources
  input wire logic vbat_above_por,
  input wire logic [1:0] vbat_level,
  input wire logic vdd_above_rst,
  input wire logic other_reset_req,
  output logic battery_monitor_en,
  output logic supply_monitor_en,
  // active-low reset pin
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic rst_pin_pullup_en,
  // core and peripheral controls
  output logic core_rst,
  output logic stack_ptr_rst,
  output logic ram_write_block,
  output logic irq_timer_disable,
  output logic [15:0] fetch_vector,
  output logic clk_sel_internal,
  output logic wdt_force_enable,
  output logic wdt_tick,
  // ports
  output logic [7:0] port_latch_value,
  output logic port_open_drain,
  output logic port_weak_pullup
);

  // ***********************************
  // state and registers
  // ***********************************
  porc_pkg::porc_state_type state;
  porc_pkg::porc_state_type next_state;
  logic [4:0] cause_flags;
  logic battery_monitor_disable;
  logic supply_mon_sel;
  logic hold_is_mon;
  logic sw_req;
  logic [3:0] wdt_div;
  logic delay_load;
  logic delay_done;
  logic [porc_pkg::DELAY_W-1:0] delay_value;

  function automatic logic [porc_pkg::DELAY_W-1:0] pick_delay(input logic [1:0] lvl);
    case (lvl)
      2'h0: pick_delay = porc_pkg::DELAY_W'(DELAY_LOW_CYC);
      2'h1: pick_delay = porc_pkg::DELAY_W'(DELAY_MID_CYC);
      default: pick_delay = porc_pkg::DELAY_W'(DELAY_HIGH_CYC);
    endcase
  endfunction : pick_delay

  // ***********************************
  // reset causes
  // ***********************************
  logic in_run;
  logic mon_trip;
  logic pin_trip;
  logic other_trip;
  logic any_trip;
  logic full_por;
  logic apb_setup;
  logic apb_access;
  logic addr_ok;

  assign in_run = (state == porc_pkg::ST_RUN);
  assign mon_trip = supply_monitor_en && supply_mon_sel && !vdd_above_rst;
  // own drive on the pin must not read back as an external reset
  assign pin_trip = !rst_pin_in && !rst_pin_oe;
  assign other_trip = pin_trip || sw_req || other_reset_req;
  assign any_trip = mon_trip || other_trip;
  // RULE13 full power-on
  assign full_por = !vbat_above_por || (battery_monitor_disable && any_trip);

  always_comb begin
    next_state = state;
    delay_load = 1'b0;
    case (state)
      porc_pkg::ST_POR_WAIT: begin
        // RULE8 battery threshold
        if (vbat_above_por) begin
          next_state = porc_pkg::ST_POR_DELAY;
          delay_load = 1'b1;
        end
      end
      porc_pkg::ST_POR_DELAY: begin
        if (!vbat_above_por) begin
          next_state = porc_pkg::ST_POR_WAIT;
        end else if (delay_done) begin
          next_state = porc_pkg::ST_RUN;
        end
      end
      porc_pkg::ST_HOLD: begin
        // RULE15 no delay
        if (!vbat_above_por) begin
          next_state = porc_pkg::ST_POR_WAIT;
        end else if (!(hold_is_mon ? !vdd_above_rst : (pin_trip || other_reset_req))) begin
          next_state = porc_pkg::ST_RUN;
        end
      end
      porc_pkg::ST_RUN: begin
        if (full_por) begin
          next_state = porc_pkg::ST_POR_WAIT;
        end else if (any_trip) begin
          next_state = porc_pkg::ST_HOLD;
        end
      end
      default: next_state = porc_pkg::ST_POR_WAIT;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= porc_pkg::ST_POR_WAIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_is_mon <= 1'b0;
    end else if (in_run && any_trip) begin
      hold_is_mon <= mon_trip;
    end
  end

  // RULE8 level delay
  assign delay_value = pick_delay(vbat_level);

  porc_delay_timer #(
    .WIDTH(porc_pkg::DELAY_W)
  ) u_delay (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(delay_load),
    .load_value(delay_value),
    .done(delay_done)
  );

  // ***********************************
  // cause flags and monitor control
  // ***********************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cause_flags <= 5'h00;
    end else if (state == porc_pkg::ST_POR_DELAY && next_state == porc_pkg::ST_RUN) begin
      // RULE9 set flag
      cause_flags <= 5'h00;
      cause_flags[porc_pkg::POWER_ON_FLAG_BIT] <= 1'b1;
    end else if (in_run && any_trip && !full_por) begin
      // RULE10 clear flag
      cause_flags <= 5'h00;
      cause_flags[porc_pkg::CAUSE_PIN_BIT] <= pin_trip;
      cause_flags[porc_pkg::CAUSE_MON_BIT] <= mon_trip;
      cause_flags[porc_pkg::CAUSE_SW_BIT] <= sw_req;
      cause_flags[porc_pkg::CAUSE_EXT_BIT] <= other_reset_req;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || state == porc_pkg::ST_POR_WAIT) begin
      // RULE13 monitor back on
      battery_monitor_disable <= 1'b0;
    end else if (core_rst) begin
      battery_monitor_disable <= 1'b0;
    end else if (apb_access && pwrite && paddr == porc_pkg::ADDR_PMU_MODE) begin
      // RULE12 monitor disable
      battery_monitor_disable <= HAS_MON_DISABLE
        && pwdata[porc_pkg::BATTERY_MONITOR_DISABLE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || state == porc_pkg::ST_POR_WAIT) begin
      supply_monitor_en <= 1'b1;
      supply_mon_sel <= 1'b1;
    end else if (in_run && mon_trip && !full_por) begin
      // RULE14 re-arm monitor
      supply_monitor_en <= 1'b1;
      supply_mon_sel <= 1'b1;
    end else if (apb_access && pwrite && !core_rst) begin
      if (paddr == porc_pkg::ADDR_SUPPLY_MON) begin
        supply_monitor_en <= pwdata[porc_pkg::SUPPLY_MON_EN_BIT];
      end
      if (paddr == porc_pkg::ADDR_CAUSE) begin
        supply_mon_sel <= pwdata[porc_pkg::POWER_ON_FLAG_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || !in_run) begin
      sw_req <= 1'b0;
    end else begin
      sw_req <= apb_access && pwrite && paddr == porc_pkg::ADDR_CAUSE
        && pwdata[porc_pkg::CAUSE_SW_BIT];
    end
  end

  assign battery_monitor_en = !battery_monitor_disable;

  // ***********************************
  // apb slave
  // ***********************************
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign addr_ok = (paddr == porc_pkg::ADDR_CAUSE) || (paddr == porc_pkg::ADDR_PMU_MODE)
    || (paddr == porc_pkg::ADDR_SUPPLY_MON) || (paddr == porc_pkg::ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_ok;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= 32'h00000000;
      case (paddr)
        porc_pkg::ADDR_CAUSE: prdata[4:0] <= cause_flags;
        porc_pkg::ADDR_PMU_MODE:
          prdata[porc_pkg::BATTERY_MONITOR_DISABLE_BIT] <= battery_monitor_disable;
        porc_pkg::ADDR_SUPPLY_MON: prdata[porc_pkg::SUPPLY_MON_EN_BIT] <= supply_monitor_en;
        porc_pkg::ADDR_STATUS: prdata[3:0] <= {supply_mon_sel, core_rst, state};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ***********************************
  // reset outputs
  // ***********************************
  // RULE16 fast assert
  assign core_rst = !in_run || full_por || any_trip;
  // RULE1 halt and defaults
  assign irq_timer_disable = core_rst;
  // RULE2 ram kept
  assign ram_write_block = core_rst;
  assign stack_ptr_rst = core_rst;
  // RULE5 pc and clock
  assign clk_sel_internal = core_rst;
  // RULE6 watchdog on
  assign wdt_force_enable = core_rst;
  // RULE3 port state
  assign port_open_drain = core_rst;
  assign port_weak_pullup = 1'b1;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_latch_value <= porc_pkg::PORT_LATCH_RESET;
      fetch_vector <= porc_pkg::RESET_VECTOR;
    end else begin
      // RULE3 latches ones
      port_latch_value <= porc_pkg::PORT_LATCH_RESET;
      // RULE7 address zero
      fetch_vector <= porc_pkg::RESET_VECTOR;
    end
  end

  // RULE6 divide by twelve
  always_ff @(posedge clock) begin
    if (sys_rst || wdt_div == 4'(porc_pkg::WDT_DIV - 1)) begin
      wdt_div <= 4'h0;
    end else begin
      wdt_div <= wdt_div + 4'h1;
    end
  end
  assign wdt_tick = (wdt_div == 4'(porc_pkg::WDT_DIV - 1));

  // RULE4 pin drive
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = (state == porc_pkg::ST_HOLD) && hold_is_mon;
  assign rst_pin_pullup_en = (state == porc_pkg::ST_HOLD) || in_run;

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_halt;
    !in_run |-> core_rst && irq_timer_disable && stack_ptr_rst && ram_write_block;
  endproperty
  a_halt: assert property (p_halt) else $error("core not held in reset"); // RULE1

  property p_ports;
    !in_run |-> port_open_drain && port_weak_pullup && port_latch_value == 8'hFF;
  endproperty
  a_ports: assert property (p_ports) else $error("ports not in reset state"); // RULE3

  property p_pin_por;
    state == porc_pkg::ST_POR_WAIT || state == porc_pkg::ST_POR_DELAY
      |-> !rst_pin_oe && !rst_pin_pullup_en;
  endproperty
  a_pin_por: assert property (p_pin_por) else $error("pin driven during power-on"); // RULE4

  property p_pin_mon;
    in_run && mon_trip && !full_por |=> rst_pin_oe && !rst_pin_out;
  endproperty
  a_pin_mon: assert property (p_pin_mon) else $error("pin not driven on monitor"); // RULE4

  property p_exit_defaults;
    $fell(core_rst) |-> fetch_vector == 16'h0000 && $past(clk_sel_internal)
      && $past(wdt_force_enable);
  endproperty
  a_exit_defaults: assert property (p_exit_defaults) else $error("bad exit defaults"); // RULE5

  property p_wdt;
    wdt_tick |=> !wdt_tick [*8] ##1 !wdt_tick [*3] ##1 wdt_tick;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog tick not every twelve"); // RULE6

  property p_delay;
    state == porc_pkg::ST_POR_WAIT && vbat_above_por |=> core_rst [*2];
  endproperty
  a_delay: assert property (p_delay) else $error("released without delay"); // RULE8

  property p_flag_set;
    state == porc_pkg::ST_POR_DELAY && next_state == porc_pkg::ST_RUN
      |=> cause_flags == 5'h02;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("power-on flag not set"); // RULE9

  property p_flag_clr;
    in_run && any_trip && !full_por |=> !cause_flags[porc_pkg::POWER_ON_FLAG_BIT];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("power-on flag kept"); // RULE10

  property p_full_por;
    in_run && battery_monitor_disable && any_trip
      |=> state == porc_pkg::ST_POR_WAIT ##1 battery_monitor_en;
  endproperty
  a_full_por: assert property (p_full_por) else $error("no full power-on"); // RULE13

  property p_mon_rearm;
    in_run && mon_trip && !full_por |=> supply_monitor_en && supply_mon_sel;
  endproperty
  a_mon_rearm: assert property (p_mon_rearm) else $error("monitor not re-armed"); // RULE14

  property p_no_delay;
    state == porc_pkg::ST_HOLD && hold_is_mon && vdd_above_rst && vbat_above_por
      |=> in_run;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("monitor reset delayed"); // RULE15

  property p_fast;
    in_run && any_trip |-> core_rst;
  endproperty
  a_fast: assert property (p_fast) else $error("reset not asserted at once"); // RULE16

  c_por_exit: cover property (state == porc_pkg::ST_POR_DELAY ##1 in_run);
  c_mon_reset: cover property (in_run && mon_trip ##1 rst_pin_oe);
  c_sw_reset: cover property (in_run && sw_req ##1 state == porc_pkg::ST_HOLD);
  c_full_por: cover property (in_run && battery_monitor_disable && any_trip);

endmodule : porc_controller

// [dv/porc_core_model.sv]
`timescale 1ns/1ps

// ***********************
// core side of the reset
// ***********************
module porc_core_model (
  // clock
  input wire logic clock,
  // from the reset controller
  input wire logic core_rst,
  input wire logic [15:0] fetch_vector,
  input wire logic wdt_tick,
  // seen by the bench
  output logic [15:0] first_fetch,
  output logic [7:0] tick_gap
);
  logic [15:0] pc;
  logic core_rst_q;
  logic [7:0] tick_cnt;

  always_ff @(posedge clock) begin
    core_rst_q <= core_rst;
    if (core_rst) begin
      pc <= fetch_vector;
    end else begin
      pc <= pc + 16'h0001;
    end
    if (core_rst_q && !core_rst) begin
      first_fetch <= pc;
    end
  end

  always_ff @(posedge clock) begin
    if (wdt_tick) begin
      tick_cnt <= 8'h01;
      tick_gap <= tick_cnt;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end
endmodule : porc_core_model

// [dv/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
  logic clock, sys_rst, psel, penable, pwrite, vbat_above_por, vdd_above_rst;
  logic other_reset_req, pin_ext_low, pready, pslverr, err, battery_monitor_en;
  logic supply_monitor_en, rst_pin_in, rst_pin_out, rst_pin_oe, rst_pin_pullup_en;
  logic core_rst, stack_ptr_rst, ram_write_block, irq_timer_disable, clk_sel_internal;
  logic wdt_force_enable, wdt_tick, port_open_drain, port_weak_pullup;
  logic [7:0] paddr, port_latch_value, tick_gap;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] vbat_level;
  logic [15:0] fetch_vector, first_fetch;
  int miscompares, tests_run, n;

  // wire level: our drive wins when enabled, else low if someone pulls low, pull-up otherwise
  assign rst_pin_in = rst_pin_oe ? rst_pin_out : !pin_ext_low;

  porc_controller #(.DELAY_LOW_CYC(20), .DELAY_MID_CYC(30), .DELAY_HIGH_CYC(40)) uut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vbat_above_por(vbat_above_por), .vbat_level(vbat_level), .vdd_above_rst(vdd_above_rst),
    .other_reset_req(other_reset_req), .battery_monitor_en(battery_monitor_en),
    .supply_monitor_en(supply_monitor_en), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .rst_pin_pullup_en(rst_pin_pullup_en), .core_rst(core_rst),
    .stack_ptr_rst(stack_ptr_rst), .ram_write_block(ram_write_block),
    .irq_timer_disable(irq_timer_disable), .fetch_vector(fetch_vector),
    .clk_sel_internal(clk_sel_internal), .wdt_force_enable(wdt_force_enable),
    .wdt_tick(wdt_tick), .port_latch_value(port_latch_value),
    .port_open_drain(port_open_drain), .port_weak_pullup(port_weak_pullup));

  porc_core_model core (.clock(clock), .core_rst(core_rst), .fetch_vector(fetch_vector),
    .wdt_tick(wdt_tick), .first_fetch(first_fetch), .tick_gap(tick_gap));

  function automatic int dly(input int lv);
    return 20 + 10 * lv;
  endfunction : dly

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  // zero wait states today, but the master waits for pready anyway
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_rel(output int c);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (core_rst !== 1'b0 && c < 500);
    if (core_rst !== 1'b0) begin
      chk("core_release", 32'h0, {31'h0, core_rst});
    end
  endtask : wait_rel

  task automatic forces(input logic [5:0] exp);
    chk("forces", {26'h0, exp}, {26'h0, stack_ptr_rst, ram_write_block, irq_timer_disable,
      clk_sel_internal, wdt_force_enable, port_open_drain});
  endtask : forces

  initial begin
    clock = 1'b0;
    forever #2 clock = !clock;
  end

  initial begin
    #(4 * 30000);
    miscompares++;
    test_done();
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, vbat_above_por, other_reset_req, pin_ext_low} = '0;
    {paddr, pwdata, vbat_level, miscompares, tests_run} = '0;
    vdd_above_rst = 1'b1;
    for (int lv = 0; lv < 3; lv++) begin
      if (lv > 0) begin
        @(posedge clock);
      end
      sys_rst <= 1'b1;
      vbat_above_por <= 1'b0;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clock);
      chk("por_pin", 32'h4, {29'h0, core_rst, rst_pin_oe, rst_pin_pullup_en});
      forces(6'h3F);
      chk("ports", 32'h3FF, {22'h0, port_latch_value, port_weak_pullup,
        port_open_drain});
      vbat_above_por <= 1'b1;
      vbat_level <= 2'(lv);
      wait_rel(n);
      chk_rng("power_on_release_delay", dly(lv), dly(lv) + 4, n);
      apb(1'b0, porc_pkg::ADDR_CAUSE, 32'h0);
      chk("cause", 32'h02, rd);
      $display("test power_on level %0d done", lv);
    end
    forces(6'h00);
    chk("first_fetch", {16'h0, porc_pkg::RESET_VECTOR}, {16'h0, first_fetch});
    chk("wdt_gap", 32'd12, {24'h0, tick_gap});
    chk("weak_pullup", 32'h1, {31'h0, port_weak_pullup});
    apb(1'b0, porc_pkg::ADDR_STATUS, 32'h0);
    chk("status_run", 32'h3, {29'h0, rd[2:0]});
    @(posedge clock);
    vdd_above_rst <= 1'b0;
    repeat (3) @(posedge clock);
    chk("monitor_hold", 32'h6, {29'h0, core_rst, rst_pin_oe, rst_pin_in});
    vdd_above_rst <= 1'b1;
    wait_rel(n);
    chk_rng("monitor_release", 1, 4, n);
    apb(1'b0, porc_pkg::ADDR_CAUSE, 32'h0);
    chk("cause_monitor", 32'h04, rd);
    chk("supply_mon_en", 32'h1, {31'h0, supply_monitor_en});
    $display("test monitor done");
    apb(1'b1, porc_pkg::ADDR_SUPPLY_MON, 32'h0);
    apb(1'b1, porc_pkg::ADDR_CAUSE, 32'h08);
    repeat (4) @(posedge clock);
    wait_rel(n);
    apb(1'b0, porc_pkg::ADDR_CAUSE, 32'h0);
    chk("cause_sw", 32'h08, rd);
    chk("supply_mon_kept", 32'h0, {31'h0, supply_monitor_en});
    @(posedge clock);
    vdd_above_rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk("monitor_off", 32'h0, {31'h0, core_rst});
    vdd_above_rst <= 1'b1;
    pin_ext_low <= 1'b1;
    repeat (3) @(posedge clock);
    forces(6'h3F);
    pin_ext_low <= 1'b0;
    wait_rel(n);
    apb(1'b0, porc_pkg::ADDR_CAUSE, 32'h0);
    chk("cause_pin", 32'h01, rd);
    $display("test software and pin done");
    apb(1'b1, porc_pkg::ADDR_PMU_MODE, 32'h20);
    // the write lands at the access edge, so look one edge later
    @(posedge clock);
    chk("batt_mon_off", 32'h0, {31'h0, battery_monitor_en});
    other_reset_req <= 1'b1;
    repeat (3) @(posedge clock);
    other_reset_req <= 1'b0;
    chk("full_por_pin", 32'h4, {29'h0, core_rst, rst_pin_oe, rst_pin_pullup_en});
    wait_rel(n);
    chk_rng("full_power_on", 40, 48, n + 3);
    apb(1'b0, porc_pkg::ADDR_CAUSE, 32'h0);
    chk("cause_full", 32'h02, rd);
    chk("batt_mon_on", 32'h1, {31'h0, battery_monitor_en});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    $display("test battery monitor and unmapped done");
    test_done();
  end
endmodule : tb_top
